// ---- core/cwr_pkg.sv ----
// Package for the cascaded watchdog and reset controller.
// Assumes a single 10 MHz system clock and an AXI4-Lite register port.
package cwr_pkg;

  // Clock and reset pulse timing.
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BUS_RST_MS = 200;
  localparam int unsigned BUS_RST_CYC = BUS_RST_MS * (CLK_HZ / 1000);
  localparam int RST_CNT_W = 22;

  // Widths.
  localparam int CNT_W = 24;
  localparam int LEAD_W = 8;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int IRQ_W = 3;
  localparam int EVSEL_W = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_LOAD1 = 6'h0d;
  localparam logic [IDX_W-1:0] IDX_LOAD2 = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_EVSEL = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h10;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 6'h11;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 6'h12;

  // Control register fields.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_KICK_BIT = 1;
  localparam int CTRL_EARLY_BIT = 2;
  localparam int CTRL_LEAD_LSB = 8;
  localparam int CTRL_STAGE_LSB = 16;

  // Event select and interrupt status bits.
  localparam int EV_NMI = 0;
  localparam int EV_SCI = 1;
  localparam int EV_SMI = 2;
  localparam int EV_RST = 3;
  localparam int IRQ_STAGE1 = 0;
  localparam int IRQ_STAGE2 = 1;
  localparam int IRQ_CONTACT = 2;

  // Reset values.
  localparam logic [CNT_W-1:0] LOAD1_RST = 24'h989680;
  localparam logic [CNT_W-1:0] LOAD2_RST = 24'h0f4240;
  localparam logic [LEAD_W-1:0] LEAD_RST = 8'h10;
  localparam logic [EVSEL_W-1:0] EVSEL_RST = 4'h0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_STAGE1, ST_STAGE2} cwr_stage_t;

endpackage : cwr_pkg

// ---- core/cwr_sync2.sv ----
// Two-flip-flop synchroniser for asynchronous pins.
// Assumes inputs come from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module cwr_sync2 import cwr_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } cwr_sync_st_t;

  cwr_sync_st_t s_q, s_d;

  always_comb begin
    s_d.meta = async_i;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= {INIT, INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.sync;

endmodule : cwr_sync2
`default_nettype wire

// ---- core/cwr_countdown.sv ----
// Loadable down counter used for each watchdog stage.
// Assumes load and run come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cwr_countdown import cwr_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic load_i,
  input wire logic [CNT_W-1:0] load_val_i,
  input wire logic run_i,
  // Count
  output logic [CNT_W-1:0] count_o
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } cwr_cnt_st_t;

  cwr_cnt_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.count = load_val_i;
    end else if (run_i && (s_q.count != '0)) begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.count;

endmodule : cwr_countdown
`default_nettype wire

// ---- core/cwr_watchdog.sv ----
// Two-stage cascaded watchdog with bus reset generator and AXI4-Lite registers.
// Assumes the kick and reset contact pins are asynchronous; everything else is on ref_clk_i.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cwr_watchdog import cwr_pkg::*; #(
  parameter int unsigned BUS_RST_CYCLES = BUS_RST_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // AXI4-Lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Pins
  input wire logic kick_input_i,
  input wire logic reset_contact_n_i,
  output logic expiry_output_o,
  output logic bus_reset_o,
  // System events
  output logic nmi_o,
  output logic sci_o,
  output logic smi_o,
  output logic irq_o
);

  typedef struct packed {
    cwr_stage_t stage;
    logic en;
    logic early_en;
    logic [LEAD_W-1:0] lead;
    logic [CNT_W-1:0] load1;
    logic [CNT_W-1:0] load2;
    logic [EVSEL_W-1:0] evsel;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] ien;
    logic irq;
    logic nmi;
    logic sci;
    logic smi;
    logic expiry;
    logic bus_rst;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic kick_prev;
    logic contact_prev;
    logic sw_kick;
    logic aw_full;
    logic [ADDR_W-1:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cwr_regs_t;

  localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(BUS_RST_CYCLES - 1);

  cwr_regs_t s_q, s_d;
  logic [1:0] pins_s;
  logic kick_s;
  logic contact_s;
  logic [CNT_W-1:0] cnt1;
  logic [CNT_W-1:0] cnt2;
  logic load1_go;
  logic load2_go;
  logic kick;
  logic contact_fall;
  logic s1_expire;
  logic s2_expire;
  logic rst_req;
  logic [IDX_W-1:0] widx;
  logic [IDX_W-1:0] ridx;
  logic [31:0] wmask;
  logic [31:0] ctrl_view;
  logic [31:0] ctrl_new;
  logic [31:0] load1_new;
  logic [31:0] load2_new;
  logic [31:0] evsel_new;
  logic [31:0] ien_new;
  logic [IRQ_W-1:0] ists_set;
  logic [IRQ_W-1:0] ists_clr;

  cwr_sync2 #(
    .WIDTH(2),
    .INIT(2'h2)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .async_i({reset_contact_n_i, kick_input_i}),
    .sync_o(pins_s)
  );

  assign kick_s = pins_s[0];
  assign contact_s = pins_s[1];

  cwr_countdown u_stage1 (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .load_i(load1_go),
    .load_val_i(s_q.load1),
    .run_i(s_q.stage == ST_STAGE1),
    .count_o(cnt1)
  );

  cwr_countdown u_stage2 (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .load_i(load2_go),
    .load_val_i(s_q.load2),
    .run_i(s_q.stage == ST_STAGE2),
    .count_o(cnt2)
  );

  assign widx = s_q.awaddr[ADDR_W-1:2];
  assign ridx = s_axi_araddr[ADDR_W-1:2];
  assign wmask = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};

  always_comb begin
    ctrl_view = '0;
    ctrl_view[CTRL_EN_BIT] = s_q.en;
    ctrl_view[CTRL_EARLY_BIT] = s_q.early_en;
    ctrl_view[CTRL_LEAD_LSB +: LEAD_W] = s_q.lead;
    ctrl_view[CTRL_STAGE_LSB +: 2] = s_q.stage;
  end

  // new register values, merged by byte lane
  assign ctrl_new = (ctrl_view & ~wmask) | (s_q.wdata & wmask);
  assign load1_new = ({8'h00, s_q.load1} & ~wmask) | (s_q.wdata & wmask);
  assign load2_new = ({8'h00, s_q.load2} & ~wmask) | (s_q.wdata & wmask);
  assign evsel_new = ({28'h0000000, s_q.evsel} & ~wmask) | (s_q.wdata & wmask);
  assign ien_new = ({29'h00000000, s_q.ien} & ~wmask) | (s_q.wdata & wmask);

  always_comb begin
    s_d = s_q;
    s_d.nmi = 1'b0;
    s_d.sci = 1'b0;
    s_d.smi = 1'b0;
    s_d.sw_kick = 1'b0;
    s_d.kick_prev = kick_s;
    s_d.contact_prev = contact_s;
    load1_go = 1'b0;
    load2_go = 1'b0;
    rst_req = 1'b0;
    ists_set = '0;
    ists_clr = '0;
    s1_expire = 1'b0;
    s2_expire = 1'b0;

    kick = s_q.en && ((kick_s && !s_q.kick_prev) || s_q.sw_kick);
    contact_fall = !contact_s && s_q.contact_prev;
    if (contact_fall) begin
      rst_req = 1'b1;
      ists_set[IRQ_CONTACT] = 1'b1;
    end

    case (s_q.stage)
      ST_IDLE: begin
        if (kick) begin
          load1_go = 1'b1;
          s_d.stage = ST_STAGE1;
        end
      end
      ST_STAGE1: begin
        if (!s_q.en) begin
          s_d.stage = ST_IDLE;
        end else if (kick) begin
          load1_go = 1'b1;
        end else if (cnt1 == '0) begin
          s1_expire = 1'b1;
          load2_go = 1'b1;
          s_d.stage = ST_STAGE2;
          s_d.nmi = s_q.evsel[EV_NMI];
          s_d.sci = s_q.evsel[EV_SCI];
          s_d.smi = s_q.evsel[EV_SMI];
          if (s_q.evsel[EV_RST]) begin
            rst_req = 1'b1;
          end
        end
      end
      ST_STAGE2: begin
        if (cnt2 == '0) begin
          s2_expire = 1'b1;
          rst_req = 1'b1;
          s_d.stage = ST_IDLE;
        end
      end
      default: begin
        s_d.stage = ST_IDLE;
      end
    endcase
    ists_set[IRQ_STAGE1] = s1_expire;
    ists_set[IRQ_STAGE2] = s2_expire;

    // early expiry ahead of the first stage end, and level through stage two
    s_d.expiry = (s_q.stage == ST_STAGE2) ||
                 (s_q.early_en && (s_q.stage == ST_STAGE1) && (cnt1 <= CNT_W'(s_q.lead)));

    // one fixed pulse per event; events inside a pulse merge into it
    if (s_q.bus_rst) begin
      if (s_q.rst_cnt == '0) begin
        s_d.bus_rst = 1'b0;
      end else begin
        s_d.rst_cnt = s_q.rst_cnt - 1'b1;
      end
    end else if (rst_req) begin
      s_d.bus_rst = 1'b1;
      s_d.rst_cnt = RST_LAST;
    end

    // Write channel: address and data are taken independently.
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (widx)
        IDX_CTRL: begin
          s_d.en = ctrl_new[CTRL_EN_BIT];
          s_d.early_en = ctrl_new[CTRL_EARLY_BIT];
          s_d.lead = ctrl_new[CTRL_LEAD_LSB +: LEAD_W];
          s_d.sw_kick = s_q.wstrb[0] && s_q.wdata[CTRL_KICK_BIT];
        end
        IDX_LOAD1: s_d.load1 = load1_new[CNT_W-1:0];
        IDX_LOAD2: s_d.load2 = load2_new[CNT_W-1:0];
        IDX_EVSEL: s_d.evsel = evsel_new[EVSEL_W-1:0];
        IDX_IRQ_STAT: s_d.bresp = RESP_OKAY;
        IDX_IRQ_CLR: ists_clr = s_q.wstrb[0] ? s_q.wdata[IRQ_W-1:0] : '0;
        IDX_IRQ_EN: s_d.ien = ien_new[IRQ_W-1:0];
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_full && !s_d.bvalid;
    s_d.wready = !s_d.w_full && !s_d.bvalid;

    // Read channel: one outstanding read, data registered on acceptance.
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      case (ridx)
        IDX_CTRL: s_d.rdata = ctrl_view;
        IDX_LOAD1: s_d.rdata = {8'h00, s_q.load1};
        IDX_LOAD2: s_d.rdata = {8'h00, s_q.load2};
        IDX_EVSEL: s_d.rdata = {28'h0000000, s_q.evsel};
        IDX_IRQ_STAT: s_d.rdata = {29'h00000000, s_q.ists};
        IDX_IRQ_CLR: s_d.rdata = '0;
        IDX_IRQ_EN: s_d.rdata = {29'h00000000, s_q.ien};
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // A status event in the same cycle as its clear stays set.
    s_d.ists = (s_q.ists & ~ists_clr) | ists_set;
    s_d.irq = |(s_d.ists & s_d.ien);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
      s_q.stage <= ST_IDLE;
      s_q.lead <= LEAD_RST;
      s_q.load1 <= LOAD1_RST;
      s_q.load2 <= LOAD2_RST;
      s_q.evsel <= EVSEL_RST;
      s_q.contact_prev <= 1'b1;
      s_q.rresp <= RESP_OKAY;
      s_q.bresp <= RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign expiry_output_o = s_q.expiry;
  assign bus_reset_o = s_q.bus_rst;
  assign nmi_o = s_q.nmi;
  assign sci_o = s_q.sci;
  assign smi_o = s_q.smi;
  assign irq_o = s_q.irq;

  // Pulse width helper, read only by the checks below.
  logic [RST_CNT_W-1:0] hi_cnt;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_cnt <= '0;
    end else if (s_q.bus_rst) begin
      hi_cnt <= hi_cnt + 1'b1;
    end else begin
      hi_cnt <= '0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s1_end_seq;
    (s_q.stage == ST_STAGE1) && s_q.en && !kick && (cnt1 == '0);
  endsequence

  sequence s2_started_seq;
    (s_q.stage == ST_STAGE2) && (cnt2 == $past(s_q.load2));
  endsequence

  chk_stage1_start: assert property ((s_q.stage == ST_IDLE) && kick |=> (s_q.stage == ST_STAGE1) && (cnt1 == $past(s_q.load1)))
    else $error("first stage did not start from its duration");
  chk_cascade_start: assert property (s1_end_seq |=> s2_started_seq)
    else $error("second stage did not start after first stage expiry");
  chk_event_select: assert property (s1_end_seq |=> (nmi_o == $past(s_q.evsel[EV_NMI])) && (sci_o == $past(s_q.evsel[EV_SCI])) && (smi_o == $past(s_q.evsel[EV_SMI])) ##1 !nmi_o)
    else $error("selected events not raised for one cycle");
  chk_final_reset: assert property ((s_q.stage == ST_STAGE2) && (cnt2 == '0) && !s_q.bus_rst |=> bus_reset_o ##1 bus_reset_o)
    else $error("second stage expiry gave no reset");
  chk_kick_reload: assert property ((s_q.stage == ST_STAGE1) && s_q.en && kick |=> (s_q.stage == ST_STAGE1) && (cnt1 == $past(s_q.load1)))
    else $error("kick did not reload first stage");
  chk_no_cancel: assert property ((s_q.stage == ST_STAGE2) && (cnt2 != '0) |=> (s_q.stage == ST_STAGE2))
    else $error("second stage was cancelled");
  chk_early_out: assert property (s_q.early_en && (s_q.stage == ST_STAGE1) && (cnt1 <= CNT_W'(s_q.lead)) |=> expiry_output_o)
    else $error("early expiry output missing");
  chk_contact_reset: assert property (!contact_s && s_q.contact_prev && !s_q.bus_rst |=> bus_reset_o)
    else $error("contact did not start a reset");
  chk_pulse_width: assert property ($fell(bus_reset_o) |-> (hi_cnt == RST_CNT_W'(BUS_RST_CYCLES)))
    else $error("bus reset pulse has wrong width");
  chk_sw_kick: assert property (s_q.sw_kick && s_q.en && (s_q.stage == ST_IDLE) |=> (s_q.stage == ST_STAGE1))
    else $error("software kick did not start the watchdog");
  chk_decode_span: assert property (s_axi_arvalid && s_axi_arready && ((ridx < IDX_CTRL) || (ridx > IDX_IRQ_EN)) |=> s_axi_rvalid && (s_axi_rresp == RESP_SLVERR))
    else $error("address outside window was not refused");
  chk_duration_cfg: assert property ((s_q.stage == ST_STAGE2) && ($past(s_q.stage) == ST_STAGE1) |-> (cnt2 == $past(s_q.load2)))
    else $error("second stage ignored its own duration");

endmodule : cwr_watchdog
`default_nettype wire

// ---- bench/cwr_pins_model.sv ----
// Model of the far side pins: an external kick source and the reset contact.
// Assumes the bench raises its requests just after a rising edge of ref_clk_i.
`timescale 1ns/10ps
`default_nettype none
module cwr_pins_model (
  // Clock
  input wire logic ref_clk_i,
  // Requests from the bench, and the watchdog expiry output
  input wire logic loop_en_i,
  input wire logic kick_req_i,
  input wire logic press_i,
  input wire logic expiry_output_i,
  // Pins
  output logic kick_input_o,
  output logic reset_contact_n_o
);
  always_ff @(posedge ref_clk_i) kick_input_o <= loop_en_i ? expiry_output_i : kick_req_i;
  assign reset_contact_n_o = ~press_i;
endmodule : cwr_pins_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the cascaded watchdog and bus reset block.
// Assumes the pin model stands on the watchdog pins; the bench is the AXI4-Lite master.
`timescale 1ns/10ps
`default_nettype none
module tb_top import cwr_pkg::*; ;
  // A short bus reset pulse keeps the run brief.
  localparam int unsigned RC = 20;
  localparam int L1 = 30;
  localparam int L2 = 60;
  logic clk, awr, wr, bv, arr, rv, kick, cn, exo, busr, nmi, sci, smi, irq;
  logic rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, loop_en = 0, kreq = 0, press = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0] bresp, rresp;
  int bad_count = 0;
  int num_checks = 0;

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  cwr_watchdog #(.BUS_RST_CYCLES(RC)) u_dut (.ref_clk_i(clk), .resetn_i(rstn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .kick_input_i(kick), .reset_contact_n_i(cn), .expiry_output_o(exo), .bus_reset_o(busr),
    .nmi_o(nmi), .sci_o(sci), .smi_o(smi), .irq_o(irq));

  cwr_pins_model u_pins (.ref_clk_i(clk), .loop_en_i(loop_en), .kick_req_i(kreq),
    .press_i(press), .expiry_output_i(exo), .kick_input_o(kick), .reset_contact_n_o(cn));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang(input string nm);
    bad_count++;
    $display("CHECK FAILED %s expected answer seen timeout", nm);
    wrap_up();
  endtask : hang

  function automatic logic sig(input int s);
    case (s)
      0: return arr;
      1: return rv;
      2: return bv;
      3: return nmi;
      4: return busr;
      default: return exo;
    endcase
  endfunction : sig

  // Counts edges until the selected output is sampled high; returns lim+1 if it never is.
  task automatic wt(input int s, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig(s) !== 1'b1 && n <= lim);
  endtask : wt

  task automatic width(output int w);
    w = 0;
    while (busr === 1'b1 && w < 100) begin
      @(posedge clk);
      w++;
    end
  endtask : width

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit ad;
    bit dd;
    n = 0;
    ad = 0;
    dd = 0;
    awv <= 1;
    awa <= a;
    wv <= 1;
    wd <= d;
    br <= 1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && awr === 1'b1) awv <= 0;
      if (!dd && wr === 1'b1) wv <= 0;
      ad = ad | (awr === 1'b1);
      dd = dd | (wr === 1'b1);
      if (++n > 50) hang("write accept");
    end
    wt(2, 50, n);
    if (n > 50) hang("write response");
    r = bresp;
    br <= 0;
    @(posedge clk);
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    arv <= 1;
    ara <= a;
    rr <= 1;
    wt(0, 50, n);
    if (n > 50) hang("read accept");
    arv <= 0;
    wt(1, 50, n);
    if (n > 50) hang("read data");
    d = rd;
    r = rresp;
    rr <= 0;
    @(posedge clk);
  endtask : axr

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    axr(8'h34, d, r);
    chk("load1 reset", 32'h989680, d);
    chk("read resp", 32'h0, 32'(r));
    axr(8'h38, d, r);
    chk("load2 reset", 32'h0f4240, d);
    axr(8'h30, d, r);
    chk("ctrl reset", 32'h1000, d);
    axr(8'h2c, d, r);
    chk("below window resp", 32'h2, 32'(r));
    chk("below window data", 32'h0, d);
    axw(8'h4c, 32'h1, r);
    chk("above window resp", 32'h2, 32'(r));
    axw(8'h34, L1, r);
    chk("write resp", 32'h0, 32'(r));
    axw(8'h38, L2, r);
    axr(8'h34, d, r);
    chk("load1", L1, d);
    axr(8'h38, d, r);
    chk("load2", L2, d);
    $display("test reset_map done");
  endtask : t_reset

  task automatic t_expiry;
    int n;
    int w;
    logic [31:0] d;
    logic [1:0] r;
    axw(8'h3c, 32'h7, r);
    axw(8'h48, 32'h7, r);
    axw(8'h30, 32'h1001, r);
    axw(8'h30, 32'h1003, r);
    wt(3, L1 + 10, n);
    chk("stage1 time", 1, 32'(n >= L1 && n <= L1 + 6));
    chk("events", 32'h7, 32'({smi, sci, nmi}));
    chk("no reset selected", 0, 32'(busr));
    kreq <= 1;
    axr(8'h30, d, r);
    kreq <= 0;
    chk("stage2 running", 32'h2, 32'(d[17:16]));
    chk("irq raised", 1, 32'(irq));
    wt(4, L2 + 10, n);
    chk("stage2 reset", 1, 32'(n >= L2 - 12 && n <= L2 + 4));
    width(w);
    chk("stage2 pulse", RC, 32'(w));
    axr(8'h40, d, r);
    chk("status", 32'h3, d);
    axw(8'h44, 32'h7, r);
    axr(8'h40, d, r);
    chk("status cleared", 32'h0, d);
    chk("irq cleared", 0, 32'(irq));
    $display("test expiry done");
  endtask : t_expiry

  task automatic t_reload;
    int n;
    int w;
    logic [1:0] r;
    axw(8'h3c, 32'h8, r);
    axw(8'h30, 32'h1003, r);
    repeat (20) @(posedge clk);
    kreq <= 1;
    repeat (3) @(posedge clk);
    kreq <= 0;
    wt(4, L1 + 20, n);
    chk("reload delays expiry", 1, 32'(n >= L1 - 4 && n <= L1 + 6));
    width(w);
    chk("stage1 reset pulse", RC, 32'(w));
    wt(4, L2 + 10, n);
    chk("stage2 follows", 1, 32'(n >= L2 - RC - 3 && n <= L2 - RC + 5));
    width(w);
    chk("stage2 pulse after stage1", RC, 32'(w));
    axw(8'h44, 32'h7, r);
    $display("test reload done");
  endtask : t_reload

  task automatic t_contact;
    int n;
    int w;
    logic [31:0] d;
    logic [1:0] r;
    axw(8'h48, 32'h3, r);
    press <= 1;
    wt(4, 10, n);
    chk("contact reset", 1, 32'(n <= 5));
    width(w);
    chk("contact pulse", RC, 32'(w));
    wt(4, 30, n);
    chk("one pulse", 1, 32'(n > 30));
    press <= 0;
    chk("masked irq", 0, 32'(irq));
    axr(8'h40, d, r);
    chk("contact status", 32'h4, d);
    axw(8'h48, 32'h7, r);
    chk("unmasked irq", 1, 32'(irq));
    axw(8'h44, 32'h4, r);
    axr(8'h40, d, r);
    chk("irq off", 0, 32'(irq));
    $display("test contact done");
  endtask : t_contact

  task automatic t_early;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    loop_en <= 1;
    axw(8'h30, 32'h1005, r);
    axw(8'h30, 32'h1007, r);
    wt(5, L1 + 10, n);
    chk("early output", 1, 32'(n <= L1 + 10));
    wt(4, 3 * L1 + L2, n);
    chk("loop holds off", 1, 32'(n > 3 * L1 + L2));
    axr(8'h30, d, r);
    chk("still stage1", 32'h1, 32'(d[17:16]));
    loop_en <= 0;
    axw(8'h30, 32'h0, r);
    $display("test early done");
  endtask : t_early

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    t_reset();
    t_expiry();
    t_reload();
    t_contact();
    t_early();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
